// ### src/uifc_pkg.sv
/*
 * Constants for the interrupt, priority and queue control block of one
 * UART channel: register offsets, field positions, reset values,
 * source codes, trigger tables and time-out figures.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package uifc_pkg;
	// register byte offsets
	localparam int AW = 8;
	localparam logic [7:0] OFS_MASK = 8'h00;
	localparam logic [7:0] OFS_SOURCE = 8'h04;
	localparam logic [7:0] OFS_QCTRL = 8'h08;
	localparam logic [7:0] OFS_FEAT = 8'h0C;
	localparam logic [7:0] OFS_LINE = 8'h10;
	localparam logic [7:0] OFS_MODEM = 8'h14;
	localparam logic [7:0] OFS_TRIGP = 8'h18;
	// interrupt_mask fields
	localparam int MK_RX = 0;
	localparam int MK_TX = 1;
	localparam int MK_LSR = 2;
	localparam int MK_MSR = 3;
	localparam int MK_CHR = 5;
	localparam int MK_RTS = 6;
	localparam int MK_CTS = 7;
	// queue_control fields
	localparam int QC_EN = 0;
	localparam int QC_RXRST = 1;
	localparam int QC_TXRST = 2;
	localparam int QC_TXSEL = 4;
	localparam int QC_RXSEL = 6;
	// feature_control fields
	localparam int FT_DSRSEL = 1;
	localparam int FT_AUTORTS = 2;
	localparam int FT_AUTOCTS = 3;
	localparam int FT_ENH = 4;
	localparam int FT_485 = 5;
	localparam int FT_TAB = 6;
	// reset values
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] FEAT_RST = 8'h00;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [15:0] TRIGP_RST = 16'h0101;
	// interrupt_source codes, bits 5:0
	localparam logic [5:0] SRC_LSR = 6'h06;
	localparam logic [5:0] SRC_RXD = 6'h04;
	localparam logic [5:0] SRC_TMO = 6'h0C;
	localparam logic [5:0] SRC_TXR = 6'h02;
	localparam logic [5:0] SRC_MSR = 6'h00;
	localparam logic [5:0] SRC_CHR = 6'h10;
	localparam logic [5:0] SRC_PIN = 6'h20;
	localparam logic [5:0] SRC_NONE = 6'h01;
	// receive time-out in character and bit times
	localparam int TMO_CHARS = 4;
	localparam int TMO_BITS = 12;
	// trigger tables, index is the two-bit selection
	localparam logic [3:0][8:0] RX_TAB_A = {9'h00E, 9'h008, 9'h004, 9'h001};
	localparam logic [3:0][8:0] TX_TAB_A = {9'h001, 9'h001, 9'h001, 9'h001};
	localparam logic [3:0][8:0] RX_TAB_B = {9'h01C, 9'h018, 9'h010, 9'h008};
	localparam logic [3:0][8:0] TX_TAB_B = {9'h01E, 9'h018, 9'h008, 9'h010};
	localparam logic [3:0][8:0] RX_TAB_C = {9'h03C, 9'h038, 9'h010, 9'h008};
	localparam logic [3:0][8:0] TX_TAB_C = {9'h038, 9'h020, 9'h010, 9'h008};
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uifc_pkg

// ### src/uifc_trig.sv
/*
 * Trigger level lookup for receive and transmit queues.
 * Assumes selections come from registers on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module uifc_trig (
	// selections
	input wire logic [1:0] table_sel,
	input wire logic [1:0] rx_sel,
	input wire logic [1:0] tx_sel,
	// programmable levels for the fourth table
	input wire logic [7:0] rx_prog,
	input wire logic [7:0] tx_prog,
	// levels
	output logic [8:0] rx_level,
	output logic [8:0] tx_level
);
	// one table field serves both directions
	always_comb begin
		case (table_sel)
			2'h0: begin
				rx_level = uifc_pkg::RX_TAB_A[rx_sel];
				tx_level = uifc_pkg::TX_TAB_A[tx_sel];
			end
			2'h1: begin
				rx_level = uifc_pkg::RX_TAB_B[rx_sel];
				tx_level = uifc_pkg::TX_TAB_B[tx_sel];
			end
			2'h2: begin
				rx_level = uifc_pkg::RX_TAB_C[rx_sel];
				tx_level = uifc_pkg::TX_TAB_C[tx_sel];
			end
			default: begin
				rx_level = {1'b0, rx_prog};
				tx_level = {1'b0, tx_prog};
			end
		endcase
	end
endmodule : uifc_trig
`default_nettype wire

// ### src/uifc_top.sv
/*
 * Interrupt enable, prioritised interrupt source and queue control for
 * one UART channel, reached over AXI4-Lite.
 * Assumes the receive/transmit datapath, modem logic and global
 * interrupt word sit on sys_clk and hand over counts and pulses here.
 */
// Summary of operation
// R1 - line error character raises line status interrupt
// R2 - errored character reaching head raises it again
// R3 - bits 4:1 head only, bit 7 any
// R4 - rx, tx, line enables reset to zero
// R5 - no queues: empty holding raises transmit ready
// R6 - queues: below trigger and empty both raise
// R7 - queues, half-duplex: empty also waits for shifter
// R8 - receive data on holding full or trigger
// R9 - source read returns highest pending source
// R10 - time-out after four chars plus twelve bits
// R11 - rising flow input pin raises change interrupt
// R12 - rising flow output pin raises change interrupt
// R13 - wake-up raises, global word read clears
// R14 - line, receive, transmit clear conditions
// R15 - modem read clears modem/pin; source read characters
// R16 - six-bit priority source codes
// R17 - bits 7:6 show queue enable
// R18 - bit 0 low while pending, resets high
// R19 - receive selection defaults zero, level one
// R20 - one trigger table for both directions
// R21 - transmit selection needs enhanced functions
// R22 - queue reset bits pulse once, self clear
// R23 - software sets enable with other bits
// R24 - any modem delta raises modem interrupt
// R25 - interrupt request follows any pending source
`timescale 1ns/1ns
`default_nettype none
module uifc_top #(
	parameter int CW = 9
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// axi4-lite write
	input wire logic [uifc_pkg::AW-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// axi4-lite read
	input wire logic [uifc_pkg::AW-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// receive side
	input wire logic [CW-1:0] rx_count,
	input wire logic rx_char_done,
	input wire logic rx_char_err,
	input wire logic rx_head_adv,
	input wire logic [3:0] rx_head_err,
	input wire logic rx_any_err,
	input wire logic receive_holding_rd,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	// transmit side
	input wire logic [CW-1:0] tx_count,
	input wire logic transmit_shifter_empty,
	input wire logic transmit_holding_wr,
	// modem and flow
	input wire logic [7:0] modem_condition,
	input wire logic flow_char_det,
	input wire logic cts_n_pin,
	input wire logic dsr_n_pin,
	input wire logic rts_n_out,
	input wire logic dtr_n_out,
	// global
	input wire logic wake_up,
	input wire logic global_interrupt_word_rd,
	// outputs
	output logic irq,
	output logic fifo_en,
	output logic rx_fifo_rst,
	output logic tx_fifo_rst,
	output logic [8:0] rx_level,
	output logic [8:0] tx_level,
	output logic modem_rd
);
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, wdata_q, rd_word;
	logic [3:0] wstrb_q;
	logic [uifc_pkg::AW-1:0] awaddr_q;
	logic wr_go, rd_hs, rd_ok;
	logic [7:0] mask_q, feat_q;
	logic [15:0] trigp_q;
	logic fifo_en_q, rx_rst_q, tx_rst_q, modem_rd_q, irq_q;
	logic [1:0] rx_sel_q, tx_sel_q, tx_sel_eff;
	logic [8:0] rx_lvl_d, tx_lvl_d, rx_level_q, tx_level_q;
	logic lsr_q, tmo_q, txr_q, chr_q, pin_q, wake_q;
	logic rd_src, rd_line, rd_modem;
	logic p_lsr, p_rxd, p_tmo, p_txr, p_msr, p_chr, p_pin, p_wake, p_any;
	logic [5:0] code;
	logic [7:0] src_word, line_word;
	logic cts_s1_q, cts_s2_q, dsr_s1_q, dsr_s2_q, flin_q, flout_q;
	logic flin, flout, pin_set;
	logic tx_below, tx_below_q, tx_empty, tx_empty_q, txr_set;
	logic [6:0] tmo_cnt_q, tmo_lim;
	logic tmo_run, tmo_set;

	assign s_awready = awready_q;
	assign s_wready = wready_q;
	assign s_bvalid = bvalid_q;
	assign s_bresp = bresp_q;
	assign s_arready = arready_q;
	assign s_rvalid = rvalid_q;
	assign s_rdata = rdata_q;
	assign s_rresp = rresp_q;
	assign irq = irq_q;
	assign fifo_en = fifo_en_q;
	assign rx_fifo_rst = rx_rst_q;
	assign tx_fifo_rst = tx_rst_q;
	assign rx_level = rx_level_q;
	assign tx_level = tx_level_q;
	assign modem_rd = modem_rd_q;

	// write channel: address and data taken in either order
	assign wr_go = !awready_q && !wready_q && !bvalid_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= uifc_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (s_awvalid && awready_q) begin
				awaddr_q <= s_awaddr;
				awready_q <= 1'b0;
			end
			if (s_wvalid && wready_q) begin
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
				wready_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				case (awaddr_q)
					uifc_pkg::OFS_MASK, uifc_pkg::OFS_QCTRL,
					uifc_pkg::OFS_FEAT, uifc_pkg::OFS_TRIGP: bresp_q <= uifc_pkg::RESP_OKAY;
					default: bresp_q <= uifc_pkg::RESP_SLVERR;
				endcase
			end
			if (bvalid_q && s_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// register writes
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mask_q <= uifc_pkg::MASK_RST; // R4
			feat_q <= uifc_pkg::FEAT_RST;
			trigp_q <= uifc_pkg::TRIGP_RST;
		end else if (wr_go) begin
			if (awaddr_q == uifc_pkg::OFS_MASK && wstrb_q[0])
				mask_q <= wdata_q[7:0];
			if (awaddr_q == uifc_pkg::OFS_FEAT && wstrb_q[0])
				feat_q <= wdata_q[7:0];
			if (awaddr_q == uifc_pkg::OFS_TRIGP && wstrb_q[0])
				trigp_q[7:0] <= wdata_q[7:0];
			if (awaddr_q == uifc_pkg::OFS_TRIGP && wstrb_q[1])
				trigp_q[15:8] <= wdata_q[15:8];
		end
	end

	// queue control: selections only move while the enable bit is written one
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fifo_en_q <= 1'b0;
			rx_sel_q <= uifc_pkg::SEL_RST; // R19
			tx_sel_q <= uifc_pkg::SEL_RST;
			rx_rst_q <= 1'b0;
			tx_rst_q <= 1'b0;
		end else begin
			rx_rst_q <= 1'b0; // R22
			tx_rst_q <= 1'b0; // R22
			if (wr_go && awaddr_q == uifc_pkg::OFS_QCTRL && wstrb_q[0]) begin
				fifo_en_q <= wdata_q[uifc_pkg::QC_EN];
				if (wdata_q[uifc_pkg::QC_EN]) begin // R23
					rx_sel_q <= wdata_q[uifc_pkg::QC_RXSEL +: 2];
					tx_sel_q <= wdata_q[uifc_pkg::QC_TXSEL +: 2];
					rx_rst_q <= wdata_q[uifc_pkg::QC_RXRST]; // R22
					tx_rst_q <= wdata_q[uifc_pkg::QC_TXRST]; // R22
				end
			end
		end
	end

	// trigger levels
	assign tx_sel_eff = feat_q[uifc_pkg::FT_ENH] ? tx_sel_q : 2'h0; // R21
	uifc_trig u_trig (
		.table_sel(feat_q[uifc_pkg::FT_TAB +: 2]), // R20
		.rx_sel(rx_sel_q),
		.tx_sel(tx_sel_eff),
		.rx_prog(trigp_q[7:0]),
		.tx_prog(trigp_q[15:8]),
		.rx_level(rx_lvl_d),
		.tx_level(tx_lvl_d)
	);
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rx_level_q <= uifc_pkg::RX_TAB_A[0];
			tx_level_q <= uifc_pkg::TX_TAB_A[0];
		end else begin
			rx_level_q <= rx_lvl_d;
			tx_level_q <= tx_lvl_d;
		end
	end

	// read side effects happen at the address handshake
	assign rd_hs = s_arvalid && arready_q;
	assign rd_src = rd_hs && s_araddr == uifc_pkg::OFS_SOURCE;
	assign rd_line = rd_hs && s_araddr == uifc_pkg::OFS_LINE;
	assign rd_modem = rd_hs && s_araddr == uifc_pkg::OFS_MODEM;

	// line word: head errors only in 4:1, any error in 7
	assign line_word = {rx_any_err, tx_count == '0 && transmit_shifter_empty,
		tx_count == '0, rx_head_err, rx_count != '0}; // R3

	always_comb begin
		rd_ok = 1'b1;
		rd_word = '0;
		case (s_araddr)
			uifc_pkg::OFS_MASK: rd_word[7:0] = mask_q;
			uifc_pkg::OFS_SOURCE: rd_word[7:0] = src_word;
			uifc_pkg::OFS_QCTRL: rd_word = '0;
			uifc_pkg::OFS_FEAT: rd_word[7:0] = feat_q;
			uifc_pkg::OFS_LINE: rd_word[7:0] = line_word;
			uifc_pkg::OFS_MODEM: rd_word[7:0] = modem_condition;
			uifc_pkg::OFS_TRIGP: rd_word[15:0] = trigp_q;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= uifc_pkg::RESP_OKAY;
			modem_rd_q <= 1'b0;
		end else begin
			modem_rd_q <= rd_modem;
			if (rd_hs) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_ok ? uifc_pkg::RESP_OKAY : uifc_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// flow input pins come from outside: two stages first
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			// idle high, so release of reset gives no false rise
			cts_s1_q <= 1'b1;
			cts_s2_q <= 1'b1;
			dsr_s1_q <= 1'b1;
			dsr_s2_q <= 1'b1;
			flin_q <= 1'b1;
			flout_q <= 1'b1;
		end else begin
			cts_s1_q <= cts_n_pin;
			cts_s2_q <= cts_s1_q;
			dsr_s1_q <= dsr_n_pin;
			dsr_s2_q <= dsr_s1_q;
			flin_q <= flin;
			flout_q <= flout;
		end
	end
	assign flin = feat_q[uifc_pkg::FT_DSRSEL] ? dsr_s2_q : cts_s2_q;
	assign flout = feat_q[uifc_pkg::FT_DSRSEL] ? dtr_n_out : rts_n_out;
	assign pin_set = (feat_q[uifc_pkg::FT_AUTOCTS] && flin && !flin_q) // R11
		|| (feat_q[uifc_pkg::FT_AUTORTS] && flout && !flout_q); // R12

	// transmit ready events
	assign tx_below = tx_count < tx_level_q;
	assign tx_empty = tx_count == '0
		&& (!fifo_en_q || !feat_q[uifc_pkg::FT_485] || transmit_shifter_empty); // R7
	assign txr_set = (tx_empty && !tx_empty_q) // R5
		|| (fifo_en_q && tx_below && !tx_below_q); // R6
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tx_below_q <= 1'b1;
			tx_empty_q <= 1'b1;
		end else begin
			tx_below_q <= tx_below;
			tx_empty_q <= tx_empty;
		end
	end

	// time-out counts bit times while data sits unread
	assign tmo_lim = 7'(uifc_pkg::TMO_CHARS * char_bits) + 7'(uifc_pkg::TMO_BITS); // R10
	assign tmo_run = fifo_en_q && rx_count != '0 && !rx_char_done && !receive_holding_rd;
	assign tmo_set = tmo_run && bit_tick && tmo_cnt_q + 7'h01 == tmo_lim; // R10
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			tmo_cnt_q <= '0;
		else if (!tmo_run)
			tmo_cnt_q <= '0;
		else if (bit_tick && tmo_cnt_q != tmo_lim)
			tmo_cnt_q <= tmo_cnt_q + 7'h01;
	end

	// sticky sources: a set in the clearing cycle wins
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lsr_q <= 1'b0;
			tmo_q <= 1'b0;
			txr_q <= 1'b0;
			chr_q <= 1'b0;
			pin_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			if ((rx_char_done && rx_char_err) // R1
				|| (rx_head_adv && |rx_head_err)) // R2
				lsr_q <= 1'b1;
			else if (rd_line)
				lsr_q <= 1'b0; // R14
			if (tmo_set)
				tmo_q <= 1'b1;
			else if (receive_holding_rd)
				tmo_q <= 1'b0; // R10
			if (txr_set)
				txr_q <= 1'b1;
			else if (rd_src || transmit_holding_wr)
				txr_q <= 1'b0; // R14
			if (flow_char_det)
				chr_q <= 1'b1;
			else if (rd_src)
				chr_q <= 1'b0; // R15
			if (pin_set)
				pin_q <= 1'b1;
			else if (rd_modem)
				pin_q <= 1'b0; // R15
			if (wake_up)
				wake_q <= 1'b1; // R13
			else if (global_interrupt_word_rd)
				wake_q <= 1'b0; // R13
		end
	end

	// pending, gated by enables except wake-up
	assign p_lsr = lsr_q && mask_q[uifc_pkg::MK_LSR]; // R1
	assign p_rxd = mask_q[uifc_pkg::MK_RX] && (fifo_en_q ? rx_count >= rx_level_q
		: rx_count != '0); // R8
	assign p_tmo = tmo_q && mask_q[uifc_pkg::MK_RX];
	assign p_txr = txr_q && mask_q[uifc_pkg::MK_TX];
	assign p_msr = |modem_condition[3:0] && mask_q[uifc_pkg::MK_MSR]; // R24
	assign p_chr = chr_q && mask_q[uifc_pkg::MK_CHR] && feat_q[uifc_pkg::FT_ENH];
	assign p_pin = pin_q && feat_q[uifc_pkg::FT_ENH]
		&& (mask_q[uifc_pkg::MK_RTS] || mask_q[uifc_pkg::MK_CTS]);
	assign p_wake = wake_q;
	assign p_any = p_lsr || p_rxd || p_tmo || p_txr || p_msr || p_chr || p_pin || p_wake;

	// lower sources wait behind the reported one
	always_comb begin
		if (p_lsr) code = uifc_pkg::SRC_LSR; // R16
		else if (p_rxd) code = uifc_pkg::SRC_RXD; // R9
		else if (p_tmo) code = uifc_pkg::SRC_TMO;
		else if (p_txr) code = uifc_pkg::SRC_TXR;
		else if (p_msr) code = uifc_pkg::SRC_MSR;
		else if (p_chr) code = uifc_pkg::SRC_CHR;
		else if (p_pin) code = uifc_pkg::SRC_PIN;
		else if (p_wake) code = uifc_pkg::SRC_MSR;
		else code = uifc_pkg::SRC_NONE; // R18
	end
	assign src_word = {fifo_en_q, fifo_en_q, code}; // R17

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			irq_q <= 1'b0;
		else
			irq_q <= p_any; // R25
	end

	// checks
	a_rx_rst_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
		rx_rst_q |=> !rx_rst_q) // R22
		else $error("rx queue reset held longer than one cycle");
	a_tx_rst_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		tx_rst_q |-> $past(wr_go) && $past(wdata_q[0])) // R22
		else $error("tx queue reset without enabled write");
	a_irq_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
		irq_q == $past(code != uifc_pkg::SRC_NONE)) // R25
		else $error("interrupt request does not match source code");
	a_none_code: assert property (@(posedge sys_clk) disable iff (!rstn)
		!p_any |-> code == uifc_pkg::SRC_NONE) // R18
		else $error("none code wrong while idle");
	a_lsr_top: assert property (@(posedge sys_clk) disable iff (!rstn)
		p_lsr |-> code == uifc_pkg::SRC_LSR) // R16
		else $error("line status not top priority");
	a_fifo_bits: assert property (@(posedge sys_clk) disable iff (!rstn)
		rd_src |=> s_rdata[7:6] == {2{$past(fifo_en_q)}}) // R17
		else $error("queue enable bits wrong in source read");
	a_lsr_set: assert property (@(posedge sys_clk) disable iff (!rstn)
		rx_char_done && rx_char_err |=> lsr_q) // R1
		else $error("line error did not latch");
	a_tx_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		transmit_holding_wr && !txr_set |=> !txr_q) // R14
		else $error("transmit ready not cleared by write");
	a_mask_reset: assert property (@(posedge sys_clk)
		rstn && !$past(rstn) |-> mask_q == 8'h00 && irq_q == 1'b0) // R4
		else $error("mask not zero after reset");
	a_txsel_plain: assert property (@(posedge sys_clk) disable iff (!rstn)
		!feat_q[uifc_pkg::FT_ENH] |-> tx_sel_eff == 2'h0) // R21
		else $error("transmit selection active without enhanced functions");
	a_tmo_raise: assert property (@(posedge sys_clk) disable iff (!rstn)
		tmo_set ##1 !receive_holding_rd |=> tmo_q) // R10
		else $error("time-out lost");
	a_wake_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		wake_up |=> wake_q ##1 irq_q) // R13
		else $error("wake-up did not raise interrupt");
	c_lsr_then_txr: cover property (@(posedge sys_clk) disable iff (!rstn)
		p_lsr && p_txr ##[1:20] code == uifc_pkg::SRC_TXR);
	c_timeout: cover property (@(posedge sys_clk) disable iff (!rstn) tmo_set);
	c_pin_change: cover property (@(posedge sys_clk) disable iff (!rstn) pin_set);
	c_rx_reset: cover property (@(posedge sys_clk) disable iff (!rstn) rx_rst_q);
endmodule : uifc_top
`default_nettype wire

// ### dv/uifc_host.sv
/*
 * Host model: AXI4-Lite master tasks for register access.
 * Assumes a slave on sys_clk that answers in its own time.
 */
`timescale 1ns/1ns
`default_nettype none
module uifc_host (
	// clock
	input wire logic sys_clk,
	// write
	output var logic [uifc_pkg::AW-1:0] awaddr,
	output var logic awvalid,
	input wire logic awready,
	output var logic [31:0] wdata,
	output var logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output var logic bready,
	// read
	output var logic [uifc_pkg::AW-1:0] araddr,
	output var logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output var logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// released payload is inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		fork
			begin
				do @(posedge sys_clk); while (awready !== 1'b1);
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			begin
				do @(posedge sys_clk); while (wready !== 1'b1);
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		join
		while (bvalid !== 1'b1) @(posedge sys_clk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		while (rvalid !== 1'b1) @(posedge sys_clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : uifc_host
`default_nettype wire

// ### dv/tb_uart_interrupt_fifo_control.sv
/*
 * Self-checking bench for the interrupt, priority and queue control block.
 * Assumes the host model drives the register bus; bench plays the datapath.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_uart_interrupt_fifo_control;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [8:0] rx_count = '0, tx_count = '0, rx_level, tx_level;
	logic rx_char_done = 0, rx_char_err = 0, rx_head_adv = 0, rx_any_err = 0;
	logic [3:0] rx_head_err = '0;
	logic rhr_rd = 0, bit_tick = 0, thr_wr = 0, flow_char = 0, cts_n = 0, rts_n = 0;
	logic wake = 0, gword_rd = 0, tsr_empty = 1, irq, fifo_en, rx_rst, tx_rst, modem_rd;
	logic [7:0] modem = '0;
	int error_cnt = 0, comparisons = 0, n_rr = 0, n_tr = 0, n_md = 0, cycles = 0;
	always #50 sys_clk = ~sys_clk;
	uifc_top uifc_top_i (.sys_clk(sys_clk), .rstn(rstn), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
		.s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
		.s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.rx_count(rx_count), .rx_char_done(rx_char_done), .rx_char_err(rx_char_err),
		.rx_head_adv(rx_head_adv), .rx_head_err(rx_head_err), .rx_any_err(rx_any_err),
		.receive_holding_rd(rhr_rd), .bit_tick(bit_tick), .char_bits(4'hA),
		.tx_count(tx_count), .transmit_shifter_empty(tsr_empty), .transmit_holding_wr(thr_wr),
		.modem_condition(modem), .flow_char_det(flow_char), .cts_n_pin(cts_n),
		.dsr_n_pin(1'b1), .rts_n_out(rts_n), .dtr_n_out(1'b1), .wake_up(wake),
		.global_interrupt_word_rd(gword_rd), .irq(irq), .fifo_en(fifo_en),
		.rx_fifo_rst(rx_rst), .tx_fifo_rst(tx_rst), .rx_level(rx_level),
		.tx_level(tx_level), .modem_rd(modem_rd));
	uifc_host uifc_host_i (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	// pulse counters; a cut-off turns a hang into a failure
	always @(posedge sys_clk) begin
		n_rr += (rx_rst === 1'b1);
		n_tr += (tx_rst === 1'b1);
		n_md += (modem_rd === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		uifc_host_i.wr(a, d, r);
		chk({30'h0, r}, {30'h0, e});
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		uifc_host_i.rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, uifc_pkg::RESP_OKAY});
	endtask : rreg
	// three cycles: sticky set, then irq
	task automatic src(input logic [7:0] e);
		cyc(3);
		rreg(uifc_pkg::OFS_SOURCE, {24'h0, e});
	endtask : src
	task automatic ticks(input int n);
		repeat (n) begin
			cyc(1);
			bit_tick <= 1'b1;
			cyc(1);
			bit_tick <= 1'b0;
		end
	endtask : ticks
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk({31'h0, irq}, 32'h0);
		src(8'h01);
		rreg(uifc_pkg::OFS_MASK, 32'h0);
		chk({23'h0, rx_level}, 32'h1);
		uifc_host_i.rd(8'h40, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, uifc_pkg::RESP_SLVERR});
		wreg(8'h40, 32'h5, uifc_pkg::RESP_SLVERR);
	endtask : t_reset
	task automatic t_rx_line();
		wreg(uifc_pkg::OFS_MASK, 32'h05, 2'h0);
		rx_count <= 9'h001;
		tx_count <= 9'h001;
		src(8'h04);
		chk({31'h0, irq}, 32'h1);
		rx_any_err <= 1'b1;
		{rx_char_done, rx_char_err} <= 2'h3;
		cyc(1);
		{rx_char_done, rx_char_err} <= 2'h0;
		src(8'h06);
		rreg(uifc_pkg::OFS_LINE, 32'h81);
		src(8'h04);
		rx_head_err <= 4'h2;
		rx_head_adv <= 1'b1;
		cyc(1);
		rx_head_adv <= 1'b0;
		src(8'h06);
		rreg(uifc_pkg::OFS_LINE, 32'h85);
		{rx_count, rx_any_err, rx_head_err} <= '0;
		src(8'h01);
	endtask : t_rx_line
	task automatic t_tx();
		wreg(uifc_pkg::OFS_MASK, 32'h02, 2'h0);
		tx_count <= 9'h000;
		src(8'h02);
		src(8'h01);
		tx_count <= 9'h001;
		cyc(2);
		tx_count <= 9'h000;
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		thr_wr <= 1'b1;
		cyc(1);
		thr_wr <= 1'b0;
		cyc(3);
		chk({31'h0, irq}, 32'h0);
	endtask : t_tx
	task automatic t_queue();
		wreg(uifc_pkg::OFS_FEAT, 32'h70, 2'h0);
		wreg(uifc_pkg::OFS_QCTRL, 32'h57, 2'h0);
		cyc(2);
		chk(n_rr + n_tr, 2);
		chk({23'h0, rx_level}, {23'h0, uifc_pkg::RX_TAB_B[1]});
		chk({23'h0, tx_level}, {23'h0, uifc_pkg::TX_TAB_B[1]});
		tx_count <= 9'h009;
		tsr_empty <= 1'b0;
		cyc(2);
		tx_count <= 9'h007;
		src(8'hC2);
		tx_count <= 9'h000;
		cyc(3);
		chk({31'h0, irq}, 32'h0);
		tsr_empty <= 1'b1;
		src(8'hC2);
		src(8'hC1);
		wreg(uifc_pkg::OFS_QCTRL, 32'h86, 2'h0);
		cyc(2);
		chk({31'h0, fifo_en}, 32'h0);
		chk(n_rr + n_tr, 2);
		src(8'h01);
		wreg(uifc_pkg::OFS_QCTRL, 32'h57, 2'h0);
	endtask : t_queue
	task automatic t_timeout();
		wreg(uifc_pkg::OFS_MASK, 32'h01, 2'h0);
		rx_count <= 9'h001;
		ticks(51);
		src(8'hC1);
		ticks(1);
		src(8'hCC);
		rhr_rd <= 1'b1;
		cyc(1);
		rhr_rd <= 1'b0;
		src(8'hC1);
		rx_count <= 9'h010;
		src(8'hC4);
		rx_count <= 9'h00F;
		src(8'hC1);
		rx_count <= 9'h000;
	endtask : t_timeout
	task automatic t_modem();
		wreg(uifc_pkg::OFS_MASK, 32'h08, 2'h0);
		modem <= 8'h01;
		src(8'hC0);
		rreg(uifc_pkg::OFS_MODEM, 32'h01);
		cyc(2);
		chk(n_md, 1);
		modem <= 8'h00;
		src(8'hC1);
	endtask : t_modem
	task automatic t_flow();
		wreg(uifc_pkg::OFS_FEAT, 32'h1C, 2'h0);
		wreg(uifc_pkg::OFS_MASK, 32'hE0, 2'h0);
		flow_char <= 1'b1;
		cyc(1);
		flow_char <= 1'b0;
		src(8'hD0);
		src(8'hC1);
		cts_n <= 1'b1;
		cyc(2);
		src(8'hE0);
		rreg(uifc_pkg::OFS_MODEM, 32'h00);
		src(8'hC1);
		rts_n <= 1'b1;
		src(8'hE0);
		rreg(uifc_pkg::OFS_MODEM, 32'h00);
		src(8'hC1);
		wake <= 1'b1;
		cyc(1);
		wake <= 1'b0;
		src(8'hC0);
		gword_rd <= 1'b1;
		cyc(1);
		gword_rd <= 1'b0;
		src(8'hC1);
	endtask : t_flow
	initial begin
		cyc(16);
		rstn <= 1'b1;
		t_reset();
		t_rx_line();
		t_tx();
		t_queue();
		t_timeout();
		t_modem();
		t_flow();
		stop_test();
	end
endmodule : tb_uart_interrupt_fifo_control
`default_nettype wire
